/* File: dv/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input  wire logic                  i_ref_clk,
	input  wire logic [7:0]            i_rdata,
	output var irq_status_pkg::reg_access_t o_host
);
	initial o_host = '0;
	// released lines show the inverse, never a stale value
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_host = '{1'b1, 1'b0, a, d};
		@(negedge i_ref_clk);
		o_host = '{1'b0, 1'b0, ~a, ~d};
	endtask
	// reading status or writing protocol control acknowledges
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge i_ref_clk);
		o_host = '{1'b0, 1'b1, a, 8'h00};
		@(negedge i_ref_clk);
		d = i_rdata;
		o_host = '{1'b0, 1'b0, ~a, 8'hFF};
	endtask
endmodule
`default_nettype wire

/* File: dv/reader_irq_status_flags_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module irq_flags_checker #(
	parameter int BUF_WIDTH = 5
)(
	input wire logic                         i_ref_clk,
	input wire logic                         i_rst,
	input wire logic                         i_chip_en,
	input wire irq_status_pkg::reg_access_t  i_host,
	input wire irq_status_pkg::link_events_t i_events,
	input wire logic [BUF_WIDTH-1:0]         i_buf_level,
	input wire logic [7:0]                   o_rdata,
	input wire logic [7:0]                   o_protocol_ctrl,
	input wire logic                         o_decoder_en,
	input wire logic                         o_irq
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	wire rd_st = i_host.rd && i_host.addr == 5'h0C;
	wire wr_pc = i_host.wr && i_host.addr == 5'h01;
	wire quiet = i_events == 8'h00;
	// sync lag: enable must be steady before flags can hold
	sequence en_ok;
		i_chip_en [*3];
	endsequence
	chk_read_drops_irq: assert property (rd_st && quiet |=> !o_irq)
		else $error("irq up after read");
	chk_ctrl_wr_clears: assert property (wr_pc && quiet |=> ##1 !o_irq)
		else $error("irq up after ctrl write");
	chk_irq_holds: assert property (en_ok ##0 (o_irq && !rd_st && !wr_pc)
		|=> o_irq)
		else $error("irq dropped");
	chk_disable_clears: assert property (!i_chip_en [*4] |-> !o_irq)
		else $error("irq up while disabled");
	chk_tx_start_quiet: assert property (i_events == 8'h80 && !o_irq
		|=> !o_irq)
		else $error("irq at tx start");
	chk_sof_quiet: assert property (i_events == 8'h20 && !o_irq
		|=> !o_irq)
		else $error("irq at rx start");
	chk_tx_end_irq: assert property (en_ok ##0 i_events.tx_end
		|=> o_irq)
		else $error("no irq at tx end");
	chk_decoder_off: assert property (i_events.tx_start
		|-> ##[1:2] !o_decoder_en)
		else $error("decoder on in tx");
	chk_decoder_on: assert property (i_events.rx_sof
		|-> ##[1:2] o_decoder_en)
		else $error("decoder off in rx");
endmodule
bind reader_irq_status_flags irq_flags_checker #(.BUF_WIDTH(BUF_WIDTH)) u_chk (
	.i_ref_clk       (i_ref_clk),
	.i_rst           (i_rst),
	.i_chip_en       (i_chip_en),
	.i_host          (i_host),
	.i_events        (i_events),
	.i_buf_level     (i_buf_level),
	.o_rdata         (o_rdata),
	.o_protocol_ctrl (o_protocol_ctrl),
	.o_decoder_en    (o_decoder_en),
	.o_irq           (o_irq)
);
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic                         clk = 1'b0;
	logic                         rst = 1'b1;
	logic                         en = 1'b1;
	irq_status_pkg::reg_access_t  host;
	irq_status_pkg::link_events_t evs = '0;
	logic [4:0]                   lvl = 5'h06;
	logic [7:0]                   rdata;
	logic                         irq;
	logic [7:0]                   st;
	logic [7:0]                   e;
	logic [4:0]                   bt [4] = '{5'h03, 5'h06, 5'h06, 5'h04};
	logic [4:0]                   br [4] = '{5'h06, 5'h09, 5'h08, 5'h06};
	int                           n_mismatch = 0;
	int                           checks = 0;
	always #25 clk = ~clk;
	reader_irq_status_flags #(.STEP_CYCLES(2)) dut (
		.i_ref_clk       (clk),
		.i_rst           (rst),
		.i_chip_en       (en),
		.i_host          (host),
		.i_events        (evs),
		.i_buf_level     (lvl),
		.o_rdata         (rdata),
		.o_protocol_ctrl (),
		.o_decoder_en    (),
		.o_irq           (irq)
	);
	host_model hm (
		.i_ref_clk (clk),
		.i_rdata   (rdata),
		.o_host    (host)
	);
	task automatic finish_test;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ev(input logic [7:0] v);
		@(negedge clk);
		evs = v;
		@(negedge clk);
		evs = '0;
	endtask
	task automatic rs(input logic [7:0] exp);
		hm.rd(5'h0C, st);
		cmp(st, exp);
	endtask
	// full exchange; error levels ride on the rx end pulse
	task automatic frame(input logic [7:0] er, input logic [4:0] t, r);
		lvl = t;
		ev(8'h80);
		cmp({7'h00, irq}, 8'h00);
		ev(8'h40);
		lvl = r;
		cmp({7'h00, irq}, 8'h01);
		ev(8'h20);
		repeat (2) @(negedge clk);
		ev({4'h1, er[4:1]});
		lvl = 5'h06;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		finish_test;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rs(8'h00);
		hm.rd(5'h0D, st);
		cmp(st, 8'h3E);
		hm.rd(5'h1F, st);
		cmp(st, 8'h00);
		hm.wr(5'h0C, 8'hFF);
		rs(8'h00);
		for (int i = 0; i < 4; i++)
		begin
			e = 8'h10 >> i;
			frame(e, bt[i], br[i]);
			rs(8'hC0 | e | ((bt[i] < 4 || br[i] > 8) ? 8'h20 : 8'h00));
			cmp({7'h00, irq}, 8'h00);
		end
		hm.wr(5'h01, 8'h80);
		frame(8'h10, 5'h06, 5'h06);
		rs(8'hC0);
		frame(8'h08, 5'h06, 5'h06);
		hm.wr(5'h01, 8'h00);
		@(negedge clk);
		cmp({7'h00, irq}, 8'h00);
		rs(8'h00);
		frame(8'h04, 5'h06, 5'h06);
		en = 1'b0;
		repeat (4) @(negedge clk);
		cmp({7'h00, irq}, 8'h00);
		en = 1'b1;
		repeat (3) @(negedge clk);
		rs(8'h00);
		hm.wr(5'h07, 8'h02);
		ev(8'h80);
		ev(8'h40);
		repeat (8) @(negedge clk);
		rs(8'h81);
		finish_test;
	end
endmodule
`default_nettype wire

/* File: hdl/irq_status_pkg.sv */
package irq_status_pkg;

	typedef enum logic [1:0]
	{
		PHASE_IDLE = 2'b00,
		PHASE_TX   = 2'b01,
		PHASE_WAIT = 2'b10,
		PHASE_RX   = 2'b11
	} phase_t;

	typedef struct packed
	{
		logic tx_start;
		logic tx_end;
		logic rx_sof;
		logic rx_end;
		logic checksum_err;
		logic parity_err;
		logic framing_err;
		logic collision;
	} link_events_t;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} reg_access_t;

endpackage

/* File: hdl/irq_status_regs.svh */
`ifndef IRQ_STATUS_REGS_SVH
`define IRQ_STATUS_REGS_SVH

`define ADDR_WIDTH            5
`define ADDR_PROTOCOL_CTRL    5'h01
`define ADDR_NORESP_WAIT      5'h07
`define ADDR_INTERRUPT_STATUS 5'h0C
`define ADDR_IRQ_MASK         5'h0D

`define STATUS_RESET          8'h00
`define MASK_RESET            8'h3E
`define NORESP_WAIT_RESET     8'h0E

`define BIT_TX                7
`define BIT_RX                6
`define BIT_BUFFER            5
`define BIT_CHECKSUM          4
`define BIT_PARITY            3
`define BIT_FRAMING           2
`define BIT_COLLISION         1
`define BIT_NORESP            0
`define BIT_NO_RX_CHECKSUM    7

`define BUFFER_HIGH_LEVEL     5'd8
`define BUFFER_LOW_LEVEL      5'd4

`define NORESP_STEP_NS        4720
`define CLOCK_PERIOD_NS       50
`define NORESP_STEP_CYCLES    ((`NORESP_STEP_NS) / (`CLOCK_PERIOD_NS))

`endif

/* File: hdl/noresp_timer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "irq_status_regs.svh"
// counts wait steps after end of transmit until a tag answer starts
module noresp_timer #(
	parameter int STEP_CYCLES = `NORESP_STEP_CYCLES
)(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_start,
	input  wire logic       i_cancel,
	input  wire logic [7:0] i_wait_steps,
	output var  logic       o_expired
);
	localparam int SW = $clog2(STEP_CYCLES + 1);

	logic [SW-1:0] step_cnt;
	logic [7:0]    steps_left;
	logic          running;
	wire           step_done = (step_cnt == SW'(STEP_CYCLES - 1));
	wire           last_step = (steps_left <= 8'h01);

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || i_cancel)
		begin
			running    <= 1'b0;
			step_cnt   <= '0;
			steps_left <= 8'h00;
			o_expired  <= 1'b0;
		end
		else if (i_start)
		begin
			running    <= 1'b1;
			step_cnt   <= '0;
			steps_left <= i_wait_steps;
			o_expired  <= 1'b0;
		end
		else
		begin
			o_expired <= 1'b0;
			if (running)
			begin
				step_cnt <= step_done ? '0 : step_cnt + SW'(1);
				if (step_done)
				begin
					steps_left <= steps_left - 8'h01;
					if (last_step)
					begin
						running   <= 1'b0;
						o_expired <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/pulse_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-flop level synchroniser, one two-flop chain per bit
module pulse_sync #(
	parameter int WIDTH = 1
)(
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output var  logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			meta   <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/reader_irq_status_flags.sv */
// Summary of operation
// - status clears to zero at power-on reset or while chip enable is low
// - any host write to protocol control clears every status flag not set in that same cycle
// - completed host read of status clears flags and drops request line
// - transmit flag bit 7 sets at start; request waits for transmit end
// - receive flag bit 6 sets on start-of-frame; request waits for end
// - bit 5 sets above 8 units at receive end or below 4 transmitting
// - bit 4 checksum error only when disable-checksum bit 7 is zero
// - bit 3 sets on parity error in received frame
// - bit 2 sets on byte framing or end-of-frame error
// - bit 1 sets when collision detector reports excess transitions
// - bit 0 sets when no answer starts within programmed wait time
// - while transmitting decoder is off; only bits 5 and 7 change
// - while receiving only bit 6 changes, without immediate request
// - per-source enables default one; no-response enable defaults zero
`timescale 1ns/1ns
`default_nettype none
`include "irq_status_regs.svh"
module reader_irq_status_flags #(
	parameter int BUF_WIDTH   = 5,
	parameter int STEP_CYCLES = `NORESP_STEP_CYCLES
)(
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_rst,
	input  wire logic                         i_chip_en,
	input  wire irq_status_pkg::reg_access_t  i_host,
	input  wire irq_status_pkg::link_events_t i_events,
	input  wire logic [BUF_WIDTH-1:0]         i_buf_level,
	output logic [7:0]                        o_rdata,
	output logic [7:0]                        o_protocol_ctrl,
	output logic                              o_decoder_en,
	output logic                              o_irq
);
	// chip enable is a pin, so it is synchronised before use
	logic chip_en_s;

	pulse_sync #(
		.WIDTH(1)
	) u_en_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst    (i_rst),
		.i_async  (i_chip_en),
		.o_sync   (chip_en_s)
	);

	irq_status_pkg::phase_t phase;
	irq_status_pkg::phase_t next_phase;
	logic [7:0] status;
	logic [7:0] next_status;
	logic [7:0] irq_mask;
	logic [7:0] noresp_wait;
	logic       noresp_hit;
	logic       next_irq;

	wire clear_all = i_rst || !chip_en_s;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] ref_a);
		hit = (a == ref_a);
	endfunction

	wire wr_proto  = i_host.wr && hit(i_host.addr, `ADDR_PROTOCOL_CTRL);
	wire wr_wait   = i_host.wr && hit(i_host.addr, `ADDR_NORESP_WAIT);
	wire wr_mask   = i_host.wr && hit(i_host.addr, `ADDR_IRQ_MASK);
	// read clears status; this path and a protocol control write acknowledge the host
	wire rd_status = i_host.rd && hit(i_host.addr, `ADDR_INTERRUPT_STATUS);

	wire in_tx = (phase == irq_status_pkg::PHASE_TX);
	wire in_rx = (phase == irq_status_pkg::PHASE_RX);
	wire tx_done = in_tx && i_events.tx_end;
	wire rx_done = in_rx && i_events.rx_end;

	// decoder stays quiet while transmitting
	wire decoder_on = !in_tx;

	wire buf_event =
		(in_rx && (i_buf_level > BUF_WIDTH'(`BUFFER_HIGH_LEVEL))) ||
		(in_tx && (i_buf_level < BUF_WIDTH'(`BUFFER_LOW_LEVEL)));

	wire rx_sof = (phase == irq_status_pkg::PHASE_WAIT) && i_events.rx_sof;

	noresp_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_noresp (
		.i_ref_clk   (i_ref_clk),
		.i_rst       (clear_all),
		.i_start     (tx_done),
		.i_cancel    (i_events.rx_sof || i_events.tx_start),
		.i_wait_steps(noresp_wait),
		.o_expired   (noresp_hit)
	);

	// phase sequencing: idle -> tx -> wait answer -> rx -> idle
	always_comb
	begin
		next_phase = phase;
		case (phase)
			irq_status_pkg::PHASE_IDLE:
				if (i_events.tx_start)
					next_phase = irq_status_pkg::PHASE_TX;
			irq_status_pkg::PHASE_TX:
				if (i_events.tx_end)
					next_phase = irq_status_pkg::PHASE_WAIT;
			irq_status_pkg::PHASE_WAIT:
				if (i_events.tx_start)
					next_phase = irq_status_pkg::PHASE_TX;
				else if (i_events.rx_sof)
					next_phase = irq_status_pkg::PHASE_RX;
				else if (noresp_hit)
					next_phase = irq_status_pkg::PHASE_IDLE;
			irq_status_pkg::PHASE_RX:
				if (i_events.rx_end)
					next_phase = irq_status_pkg::PHASE_IDLE;
			default:
				next_phase = irq_status_pkg::PHASE_IDLE;
		endcase
	end

	// per-bit set terms; errors land with the end of reception so that
	// during receive only the receive flag moves
	logic [7:0] set_bits;
	always_comb
	begin
		set_bits = 8'h00;
		set_bits[`BIT_TX] = (phase == irq_status_pkg::PHASE_IDLE ||
			phase == irq_status_pkg::PHASE_WAIT) && i_events.tx_start;
		set_bits[`BIT_RX] = rx_sof;
		set_bits[`BIT_BUFFER] = buf_event;
		if (rx_done)
		begin
			set_bits[`BIT_CHECKSUM] = i_events.checksum_err &&
				!o_protocol_ctrl[`BIT_NO_RX_CHECKSUM];
			set_bits[`BIT_PARITY]    = i_events.parity_err;
			set_bits[`BIT_FRAMING]   = i_events.framing_err;
			set_bits[`BIT_COLLISION] = i_events.collision;
		end
		set_bits[`BIT_NORESP] = (phase == irq_status_pkg::PHASE_WAIT) &&
			noresp_hit && !i_events.rx_sof;
		// transmit gating: only buffer and transmit flags may move
		if (in_tx)
			set_bits = set_bits & 8'hA0;
		// receive gating: only the receive flag, errors at the phase end
		if (in_rx && !rx_done)
			set_bits = set_bits & 8'h40;
	end

	// set wins over a same-cycle read or control write
	always_comb
	begin
		next_status = status;
		if (rd_status || wr_proto)
			next_status = `STATUS_RESET;
		next_status = next_status | set_bits;
	end

	// tx and rx flags always request; others gated by mask
	wire [7:0] enabled = {2'b11, irq_mask[5:0]};
	wire [7:0] after_end = (status | set_bits) & enabled;
	wire       phase_end = tx_done || rx_done ||
		set_bits[`BIT_NORESP];

	always_comb
	begin
		next_irq = o_irq;
		if (rd_status || wr_proto)
			next_irq = 1'b0;
		if (phase_end && (after_end != 8'h00))
			next_irq = 1'b1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (clear_all)
		begin
			phase <= irq_status_pkg::PHASE_IDLE;
			status <= `STATUS_RESET;
			o_irq <= 1'b0;
		end
		else
		begin
			phase <= next_phase;
			status <= next_status;
			o_irq <= next_irq;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (clear_all)
		begin
			o_protocol_ctrl <= 8'h00;
			noresp_wait <= `NORESP_WAIT_RESET;
			irq_mask <= `MASK_RESET;
		end
		else
		begin
			if (wr_proto)
				o_protocol_ctrl <= i_host.wdata;
			if (wr_wait)
				noresp_wait <= i_host.wdata;
			if (wr_mask)
				irq_mask <= i_host.wdata;
		end
	end

	wire [7:0] rd_mux =
		hit(i_host.addr, `ADDR_INTERRUPT_STATUS) ? status :
		hit(i_host.addr, `ADDR_PROTOCOL_CTRL) ? o_protocol_ctrl :
		hit(i_host.addr, `ADDR_NORESP_WAIT) ? noresp_wait :
		hit(i_host.addr, `ADDR_IRQ_MASK) ? irq_mask : 8'h00;

	always_ff @(posedge i_ref_clk)
	begin
		if (clear_all)
		begin
			o_rdata <= 8'h00;
			o_decoder_en <= 1'b0;
		end
		else
		begin
			if (i_host.rd)
				o_rdata <= rd_mux;
			o_decoder_en <= decoder_on;
		end
	end
endmodule
`default_nettype wire
